// >>> aptc_core_model.sv
// Behavioural shared conversion core facing the trigger block.
module aptc_core_model (
    input wire mclk,
    input wire reset_n,
    input wire slow,
    input wire conv_req,
    output reg conv_ack,
    output reg conv_done
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [7:0] busy_r;
    // One conversion at a time; slow mode lets triggers pile up.
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            busy_r <= 8'h00;
            conv_ack <= 1'b0;
            conv_done <= 1'b0;
        end else begin
            conv_ack <= 1'b0;
            conv_done <= busy_r == 8'h01;
            if (busy_r != 8'h00)
                busy_r <= busy_r - 8'h01;
            else if (conv_req && !conv_ack) begin
                conv_ack <= 1'b1;
                busy_r <= slow ? 8'h14 : 8'h03;
            end
        end
    end
endmodule

// >>> aptc_defines.vh
// Register offsets, field positions, trigger codes and reset values.
`ifndef APTC_DEFINES_VH
`define APTC_DEFINES_VH

// Word offsets of the two pair control registers (byte address = 4 * index).
`define APTC_IDX_CTRL_6_7 2'h0
`define APTC_IDX_CTRL_8_9 2'h1
// Status of the shared conversion core, read only.
`define APTC_IDX_STATUS 2'h2

// Field positions inside one byte-wide pair field.
`define APTC_F_IRQEN 7
`define APTC_F_PEND 6
`define APTC_F_SWTRG 5
`define APTC_F_SEL_HI 4
`define APTC_F_SEL_LO 0

// Upper pair sits in bits 15-8, lower pair in bits 7-0.
`define APTC_UPPER_LSB 8
`define APTC_LOWER_LSB 0

// Reset value of each control register.
`define APTC_CTRL_RESET 16'h0000

// Trigger source selector codes.
`define APTC_SRC_OFF 5'h00
`define APTC_SRC_SOFT 5'h01
`define APTC_SRC_GLOBAL 5'h02
`define APTC_SRC_SPEC_PRI 5'h03
`define APTC_SRC_PRI_FIRST 5'h04
`define APTC_SRC_PRI_LAST 5'h0B
`define APTC_SRC_TMR1 5'h0C
`define APTC_SRC_SPEC_SEC 5'h0D
`define APTC_SRC_SEC_FIRST 5'h0E
`define APTC_SRC_SEC_LAST 5'h16
`define APTC_SRC_CL_FIRST 5'h17
`define APTC_SRC_CL_LAST 5'h1E
`define APTC_SRC_TMR2 5'h1F

// Number of pairs handled by this block.
`define APTC_NPAIR 4

`endif

// >>> aptc_properties.sv
// Port-level checker for the pair trigger control block.
module aptc_properties (
    input wire mclk,
    input wire reset_n,
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    input wire conv_req,
    input wire [3:0] conv_pair,
    input wire conv_ack,
    input wire conv_done,
    input wire [3:0] pair_irq
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    // The core accepting a request, and the core finishing one.
    sequence s_ack;
        conv_req && conv_ack;
    endsequence
    sequence s_done;
        conv_done && |conv_pair;
    endsequence
    chk_wait_short: assert property (
        $fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low too long");
    chk_wait_cause: assert property (
        !avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("waitrequest low without access");
    chk_req_drop: assert property (s_ack |=> !conv_req)
        else $error("request kept after ack");
    chk_req_pair: assert property (
        conv_req |-> $onehot(conv_pair))
        else $error("request without one pair");
    chk_pair_hold: assert property (
        |conv_pair && !conv_done |=> $stable(conv_pair))
        else $error("pair changed before done");
    chk_done_clear: assert property (s_done |=> conv_pair == 4'h0)
        else $error("pair kept after done");
    chk_irq_cause: assert property (
        |pair_irq |-> $past(conv_done) && $onehot(pair_irq))
        else $error("irq without completion");
    chk_irq_pulse: assert property (
        |pair_irq |=> pair_irq == 4'h0)
        else $error("irq longer than one cycle");
endmodule
bind aptc_top aptc_properties chk (.mclk(mclk), .reset_n(reset_n),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .conv_req(conv_req),
    .conv_pair(conv_pair), .conv_ack(conv_ack), .conv_done(conv_done),
    .pair_irq(pair_irq));

// >>> aptc_src_mux.v
// Trigger source multiplexer for one pair: selector code to one trigger bit.
`include "aptc_defines.vh"

module aptc_src_mux (
    input wire [4:0] sel,
    input wire soft_trig,
    input wire global_trig,
    input wire spec_pri,
    input wire spec_sec,
    input wire [7:0] pwm_pri,
    input wire [8:0] pwm_sec,
    input wire [7:0] pwm_cl,
    input wire tmr1_match,
    input wire tmr2_match,
    output reg trig
);

    reg [4:0] ofs;

    // Ranges of generator triggers are indexed by offset from the range start.
    always @* begin
        ofs = 5'h00;
        trig = 1'b0;
        if (sel == `APTC_SRC_OFF) begin
            trig = 1'b0;
        end else if (sel == `APTC_SRC_SOFT) begin
            trig = soft_trig;
        end else if (sel == `APTC_SRC_GLOBAL) begin
            trig = global_trig;
        end else if (sel == `APTC_SRC_SPEC_PRI) begin
            trig = spec_pri;
        end else if (sel <= `APTC_SRC_PRI_LAST) begin
            ofs = sel - `APTC_SRC_PRI_FIRST;
            trig = pwm_pri[ofs[2:0]];
        end else if (sel == `APTC_SRC_TMR1) begin
            trig = tmr1_match;
        end else if (sel == `APTC_SRC_SPEC_SEC) begin
            trig = spec_sec;
        end else if (sel <= `APTC_SRC_SEC_LAST) begin
            ofs = sel - `APTC_SRC_SEC_FIRST;
            trig = pwm_sec[ofs[3:0]];
        end else if (sel <= `APTC_SRC_CL_LAST) begin
            ofs = sel - `APTC_SRC_CL_FIRST;
            trig = pwm_cl[ofs[2:0]];
        end else begin
            trig = tmr2_match;
        end
    end

endmodule

// >>> aptc_top.v
// Conversion trigger control for analog pairs 6 to 9 with Avalon-MM slave.
//
// Functional notes
// - Interrupt enable set: pulse a pair's request when its conversion completes.
// - Pending flag sets on the selected trigger, clears when conversion completes.
// - Soft trigger bit starts a conversion; cleared when pending becomes set.
// - Five-bit selector per pair, bits 12-8 upper, 4-0 lower; zero disables.
// - Code 00001 selects the pair's own soft trigger bit.
// - Code 00010 selects the global software trigger.
// - Code 00011 selects the primary PWM special event trigger.
// - Codes 00100 to 01011 select PWM generator 1 to 8 primary triggers.
// - Code 01100 selects timer 1 period match, 11111 timer 2.
// - Code 01101 selects the secondary PWM special event trigger.
// - Codes 01110 to 10110 select PWM generator 1 to 9 secondary triggers.
// - Codes 10111 to 11110 select PWM generator 1 to 8 current-limit triggers.
// - Triggered pair waits pending until the shared converter is free.
// - Pair 6 is AN13/AN12, 7 AN15/AN14, 8 AN17/AN16, 9 AN19/AN18.
`include "aptc_defines.vh"

////////////////////////////////////////////////////////////////////////
// Structure: four identical pair slices, each with its own control field,
// trigger multiplexer and pending flag, feed one arbiter that hands the
// shared converter to one pair at a time. The register bus reaches the
// fields through two 16-bit words, one byte lane per pair.
// The arbiter always favours the lowest pending pair. A pair that is
// retriggered at a high rate still cannot starve the pairs above it, as its
// flag is clear at the idle edge after each of its conversions.
// Interrupt pulses are one cycle wide and carry no sticky state here;
// whoever collects them must latch them.
////////////////////////////////////////////////////////////////////////

module aptc_top (
    // Clock and reset.
    input wire mclk,
    input wire reset_n,
    // Register bus.
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // Trigger sources, active high, sampled on every edge.
    input wire global_soft_trig,
    input wire spec_pri_trig,
    input wire spec_sec_trig,
    input wire [7:0] pwm_pri_trig,
    input wire [8:0] pwm_sec_trig,
    input wire [7:0] pwm_cl_trig,
    input wire tmr1_match,
    input wire tmr2_match,
    // Shared converter handshake.
    output reg conv_req,
    output reg [3:0] conv_pair,
    input wire conv_ack,
    input wire conv_done,
    // Completion interrupt pulses, bit 0 for pair 6.
    output reg [3:0] pair_irq
);

    localparam ST_IDLE = 2'b00;
    localparam ST_WAIT = 2'b01;
    localparam ST_BUSY = 2'b10;

    reg [1:0] state_r;
    reg [1:0] cur_r;
    reg [1:0] cur_nxt;
    reg access_done_r;

    wire [3:0] trig;
    wire [3:0] pend;
    wire [1:0] widx;
    wire wr_hit;
    wire rd_cycle;
    wire [3:0] done_pair;
    wire [3:0] irq_en;
    wire [3:0] cur_hot;
    wire irq_cur;
    // Byte-wide field per pair, packed for readback: pair 6 in bits 7-0,
    // 7 in 15-8, 8 in 23-16, 9 in 31-24. The flip-flops themselves live in
    // the pair slices, so each has a single writer.
    wire [8*`APTC_NPAIR-1:0] fields;

    assign widx = avs_address[1:0];
    assign wr_hit = avs_write & ~access_done_r & (avs_address[3:2] == 2'b00);
    assign rd_cycle = avs_read & ~access_done_r;
    // One-hot form of the pair now owning the converter, and its enable.
    assign cur_hot = 4'h1 << cur_r;
    assign irq_cur = irq_en[cur_r];

    ////////////////////////////////////////////////////////////////////////
    // Per pair: trigger selection and control field update.
    genvar g;
    generate
        for (g = 0; g < `APTC_NPAIR; g = g + 1) begin : pair
            // Register and byte lane that hold this pair's field.
            localparam [1:0] RIDX = (g < 2) ? `APTC_IDX_CTRL_6_7
                                            : `APTC_IDX_CTRL_8_9;
            localparam integer LANE = g % 2;
            reg irq_en_r;
            reg pend_r;
            reg soft_r;
            reg [4:0] sel_r;
            wire lane_wr;
            wire [7:0] wbyte;
            wire set_pend;

            assign lane_wr = wr_hit & (widx == RIDX) & avs_byteenable[LANE];
            assign wbyte = avs_writedata[8*LANE+7:8*LANE];
            assign pend[g] = pend_r;
            assign irq_en[g] = irq_en_r;
            assign done_pair[g] = (state_r == ST_BUSY) & conv_done &
                                  cur_hot[g];
            // Only a trigger that finds the flag clear is taken; one that
            // arrives while a request waits or converts is absorbed.
            assign set_pend = trig[g] & ~pend_r;
            // Readback image: bit 7 enable, 6 pending, 5 soft, 4-0 selector,
            // the same layout in either byte lane.
            assign fields[8*g+7:8*g] = {irq_en_r, pend_r, soft_r, sel_r};

            aptc_src_mux u_mux (
                .sel(sel_r),
                .soft_trig(soft_r),
                .global_trig(global_soft_trig),
                .spec_pri(spec_pri_trig),
                .spec_sec(spec_sec_trig),
                .pwm_pri(pwm_pri_trig),
                .pwm_sec(pwm_sec_trig),
                .pwm_cl(pwm_cl_trig),
                .tmr1_match(tmr1_match),
                .tmr2_match(tmr2_match),
                .trig(trig[g])
            );

            // Enable and selector are plain software bits of the lane.
            always @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    irq_en_r <= 1'b0;
                    sel_r <= `APTC_SRC_OFF;
                end else if (lane_wr) begin
                    irq_en_r <= wbyte[`APTC_F_IRQEN];
                    sel_r <= wbyte[`APTC_F_SEL_HI:`APTC_F_SEL_LO];
                end
            end

            // Pending is owned by hardware; software writes to it are
            // ignored. If a fresh trigger and a completion meet while the
            // flag is clear, the set wins.
            always @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    pend_r <= 1'b0;
                end else if (set_pend) begin
                    pend_r <= 1'b1;
                end else if (done_pair[g]) begin
                    pend_r <= 1'b0;
                end
            end

            // The soft bit clears as pending sets. A write of 1 in that
            // same cycle is dropped, as its request has just been taken.
            always @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    soft_r <= 1'b0;
                end else if (set_pend) begin
                    soft_r <= 1'b0;
                end else if (lane_wr & wbyte[`APTC_F_SWTRG]) begin
                    soft_r <= 1'b1;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Pick the lowest pending pair for the shared converter. With nothing
    // pending the old index is kept, which leaves the status word showing
    // the pair that was served last.
    always @* begin
        cur_nxt = cur_r;
        if (pend[0]) begin
            cur_nxt = 2'd0;
        end else if (pend[1]) begin
            cur_nxt = 2'd1;
        end else if (pend[2]) begin
            cur_nxt = 2'd2;
        end else if (pend[3]) begin
            cur_nxt = 2'd3;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Converter handshake: one pair at a time, others stay pending.
    // The pair index on conv_pair maps 0..3 to pairs 6..9 (AN12 to AN19).
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            cur_r <= 2'd0;
            conv_req <= 1'b0;
            conv_pair <= 4'h0;
            pair_irq <= 4'h0;
        end else begin
            pair_irq <= 4'h0;
            case (state_r)
                ST_IDLE: begin
                    // The chosen pair is frozen in cur_r for the whole
                    // conversion; the other pairs simply keep their flags.
                    if (|pend) begin
                        cur_r <= cur_nxt;
                        conv_pair <= 4'h1 << cur_nxt;
                        conv_req <= 1'b1;
                        state_r <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // Request holds until the core is free and accepts.
                    if (conv_ack) begin
                        conv_req <= 1'b0;
                        state_r <= ST_BUSY;
                    end
                end
                ST_BUSY: begin
                    // Completion frees the converter; the pending flag of
                    // this pair drops at the same edge in its slice.
                    if (conv_done) begin
                        // Gated by the pair's enable, so a masked pair
                        // finishes silently.
                        pair_irq <= {3'b000, irq_cur} << cur_r;
                        conv_pair <= 4'h0;
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    conv_req <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: one wait cycle, answer on the second edge.
    // Waitrequest idles high so each access takes exactly two edges; the
    // flag access_done_r keeps a held request from being taken twice.
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
            access_done_r <= 1'b0;
        end else begin
            if ((avs_read | avs_write) & ~access_done_r) begin
                access_done_r <= 1'b1;
                avs_waitrequest <= 1'b0;
            end else begin
                access_done_r <= 1'b0;
                avs_waitrequest <= 1'b1;
            end
        end
    end

    // Read data is captured at the taking edge and then simply held, so
    // it stands at the edge where waitrequest is seen low.
    // Status word: bits 7-6 current pair index, bits 1-0 handshake state.
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            avs_readdata <= 32'h00000000;
        end else begin
            if (rd_cycle) begin
                case (avs_address)
                    {2'b00, `APTC_IDX_CTRL_6_7}:
                        avs_readdata <= {16'h0000, fields[15:0]};
                    {2'b00, `APTC_IDX_CTRL_8_9}:
                        avs_readdata <= {16'h0000, fields[31:16]};
                    {2'b00, `APTC_IDX_STATUS}:
                        avs_readdata <= {24'h000000, cur_r, 4'h0, state_r};
                    default:
                        avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end

endmodule

// >>> aptc_top_test.sv
// Self-checking bench for the pair trigger control block.
module aptc_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    reg mclk = 0, reset_n = 0, rd = 0, wr = 0, slow = 0;
    reg [3:0] adr = 4'h0;
    reg [3:0] be = 4'h3;
    reg [15:0] wd = 16'h0000;
    reg [31:0] src = 32'h0, q;
    wire [31:0] rdata;
    wire wreq, req, ack, done;
    wire [3:0] pair, irq;
    integer err_count = 0, compares = 0, cyc = 0, n, c;
    aptc_top DUT (.mclk(mclk), .reset_n(reset_n), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_writedata({16'h0000, wd}),
        .avs_byteenable(be), .avs_readdata(rdata),
        .avs_waitrequest(wreq), .global_soft_trig(src[2]),
        .spec_pri_trig(src[3]), .spec_sec_trig(src[13]),
        .pwm_pri_trig(src[11:4]), .pwm_sec_trig(src[22:14]),
        .pwm_cl_trig(src[30:23]), .tmr1_match(src[12]),
        .tmr2_match(src[31]), .conv_req(req), .conv_pair(pair),
        .conv_ack(ack), .conv_done(done), .pair_irq(irq));
    aptc_core_model core (.mclk(mclk), .reset_n(reset_n), .slow(slow),
        .conv_req(req), .conv_ack(ack), .conv_done(done));
    initial forever #5 mclk = ~mclk;
    // A hang ends the run; the ceiling is far above the normal length.
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            err_count = err_count + 1;
            stop_test;
        end
    end
    // Comparison, bus access, irq wait and closing report.
    task chk(input [63:0] nm, input [31:0] exp, input [31:0] got);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("BAD %0s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    task bus(input [3:0] a, input r, input [15:0] d);
        begin
            adr <= a;
            rd <= r;
            wr <= !r;
            wd <= d;
            @(posedge mclk);
            while (wreq !== 1'b0) @(posedge mclk);
            q = rdata;
            rd <= 1'b0;
            wr <= 1'b0;
            @(posedge mclk);
        end
    endtask
    task wait_irq(input [3:0] m);
        begin
            n = 0;
            while ((irq & m) === 4'h0 && n < 200) begin
                @(posedge mclk);
                n = n + 1;
            end
            chk("irq", m, irq & m);
        end
    endtask
    task stop_test;
        begin
            $display("compares %0d err_count %0d", compares, err_count);
            if (err_count == 0 && compares > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask
    // Pending is read only; unmapped and reset words read zero.
    task t_regs;
        begin
            bus(4'h0, 1'b0, 16'hDFDF);
            bus(4'h0, 1'b1, 16'h0000);
            chk("ctrl", 32'h9F9F, q);
            be <= 4'h2;
            bus(4'h0, 1'b0, 16'h0000);
            be <= 4'h3;
            bus(4'h0, 1'b1, 16'h0000);
            chk("lane", 32'h009F, q);
            bus(4'h3, 1'b1, 16'h0000);
            chk("unmap", 32'h0, q);
            bus(4'h1, 1'b1, 16'h0000);
            chk("rst", 32'h0, q);
            bus(4'h0, 1'b0, 16'h0000);
            $display("t_regs done");
        end
    endtask
    // Own soft bit on pair 6 with a slow core.
    task t_soft;
        begin
            slow <= 1'b1;
            bus(4'h0, 1'b0, 16'h0081);
            bus(4'h0, 1'b0, 16'h00A1);
            bus(4'h0, 1'b1, 16'h0000);
            chk("pend", 32'h00C1, q);
            wait_irq(4'h1);
            bus(4'h0, 1'b1, 16'h0000);
            chk("clear", 32'h0081, q);
            $display("t_soft done");
        end
    endtask
    // Every hardware code on pair 9; all other sources must be ignored.
    task t_src;
        begin
            slow <= 1'b0;
            for (c = 2; c < 32; c = c + 1) begin
                bus(4'h1, 1'b0, {3'b100, c[4:0], 8'h00});
                src <= ~(32'h1 << c) & 32'hFFFFFFFC;
                @(posedge mclk);
                src <= 32'h0;
                bus(4'h1, 1'b1, 16'h0000);
                chk("sel", {19'h0, c[4:0], 8'h00} | 32'h8000, q);
                src <= 32'h1 << c;
                @(posedge mclk);
                src <= 32'h0;
                wait_irq(4'h8);
            end
            $display("t_src done");
        end
    endtask
    // Two pairs on global trigger, retrigger while pending, irq masked.
    task t_queue;
        reg [11:0] al;
        reg [3:0] il;
        begin
            slow <= 1'b1;
            bus(4'h0, 1'b0, 16'h0082);
            bus(4'h1, 1'b0, 16'h0200);
            al = 12'h000;
            il = 4'h0;
            for (n = 0; n < 150; n = n + 1) begin
                src <= (n == 0 || n == 5) ? 32'h4 : 32'h0;
                @(posedge mclk);
                if (ack === 1'b1)
                    al = {al[7:0], pair};
                il = il | irq;
            end
            chk("acks", 32'h018, {20'h0, al});
            chk("irqs", 32'h1, {28'h0, il});
            bus(4'h2, 1'b1, 16'h0000);
            chk("status", 32'hC0, q);
            $display("t_queue done");
        end
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        t_regs;
        t_soft;
        t_src;
        t_queue;
        stop_test;
    end
endmodule
